// ---- src/sbst_tap.v ----
// Functional notes
// - TMS sampled on TCK rise steers state
// - TDO changes only after TCK falls
// - ID holds revision, part, vendor fields
// - ID bit zero is constant one
// - path lengths 3, 1, 32, 109
// - code 000 boundary path, oe cell drives
// - code 001 selects fixed identification code
// - code 010 boundary path, outputs floated
// - code 100 samples ring, boundary path
// - code 111 selects one-bit skip register
// - five TMS-high edges reset the TAP
// - reset loads IDCODE into instruction
// - capture-IR loads 01 into low bits
// - bit 108 enables outputs under EXTEST
`include "sbst_tap_regs.vh"
module sbst_tap #(
	parameter [2:0] REVISION = 3'h0, // arbitrary value
	parameter [16:0] PART_TYPE = 17'h00ABC, // arbitrary value
	parameter [10:0] VENDOR = 11'h055 // arbitrary value
) (
	input wire CLOCK,
	input wire RST_N,
	input wire TCK,
	input wire TMS,
	input wire TDI,
	input wire [`SBST_BSR_LEN-1:0] RING_IN,
	output reg TDO,
	output reg TDO_OE,
	output reg [`SBST_BSR_LEN-1:0] RING_OUT,
	output reg RING_DRIVE,
	output reg Q_OE
);
	// ----------------------------------------
	// pin synchronisers and edge detect
	// ----------------------------------------
	reg [1:0] tck_s;
	reg [1:0] tms_s;
	reg [1:0] tdi_s;
	reg tck_d;
	wire rise;
	wire fall;
	// first stage read only by the second
	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			tck_s <= 2'h0;
			tms_s <= 2'h3;
			tdi_s <= 2'h3;
			tck_d <= 1'b0;
		end else begin
			tck_s <= {tck_s[0], TCK};
			tms_s <= {tms_s[0], TMS};
			tdi_s <= {tdi_s[0], TDI};
			tck_d <= tck_s[1];
		end
	end
	assign rise = tck_s[1] & ~tck_d;
	assign fall = ~tck_s[1] & tck_d;
	wire tms = tms_s[1];
	wire tdi = tdi_s[1];

	// ----------------------------------------
	// tap state machine
	// ----------------------------------------
	reg [3:0] state;
	reg [3:0] next_state;
	// next state from sampled TMS
	always @* begin
		next_state = state;
		case (state)
			`SBST_TLR: next_state = tms ? `SBST_TLR : `SBST_RTI;
			`SBST_RTI: next_state = tms ? `SBST_SELDR : `SBST_RTI;
			`SBST_SELDR: next_state = tms ? `SBST_SELIR : `SBST_CAPDR;
			`SBST_CAPDR: next_state = tms ? `SBST_EX1DR : `SBST_SHDR;
			`SBST_SHDR: next_state = tms ? `SBST_EX1DR : `SBST_SHDR;
			`SBST_EX1DR: next_state = tms ? `SBST_UPDR : `SBST_PDR;
			`SBST_PDR: next_state = tms ? `SBST_EX2DR : `SBST_PDR;
			`SBST_EX2DR: next_state = tms ? `SBST_UPDR : `SBST_SHDR;
			`SBST_UPDR: next_state = tms ? `SBST_SELDR : `SBST_RTI;
			`SBST_SELIR: next_state = tms ? `SBST_TLR : `SBST_CAPIR;
			`SBST_CAPIR: next_state = tms ? `SBST_EX1IR : `SBST_SHIR;
			`SBST_SHIR: next_state = tms ? `SBST_EX1IR : `SBST_SHIR;
			`SBST_EX1IR: next_state = tms ? `SBST_UPIR : `SBST_PIR;
			`SBST_PIR: next_state = tms ? `SBST_EX2IR : `SBST_PIR;
			`SBST_EX2IR: next_state = tms ? `SBST_UPIR : `SBST_SHIR;
			`SBST_UPIR: next_state = tms ? `SBST_SELDR : `SBST_RTI;
			default: next_state = `SBST_TLR;
		endcase
	end

	// ----------------------------------------
	// scan registers
	// ----------------------------------------
	reg [`SBST_IR_LEN-1:0] ir_shift;
	reg [`SBST_IR_LEN-1:0] ir;
	reg skip;
	reg [`SBST_ID_LEN-1:0] id_shift;
	reg [`SBST_BSR_LEN-1:0] bsr;
	wire [`SBST_ID_LEN-1:0] id_value;
	wire bsr_sel;
	// hardwired identification word
	assign id_value = {REVISION, PART_TYPE, VENDOR, `SBST_ID_PRESENT};
	// reserved codes fall back to the skip path
	assign bsr_sel = (ir == `SBST_IR_EXTEST) | (ir == `SBST_IR_FLOAT) |
		(ir == `SBST_IR_SAMPLE);

	// state and shifting on each TCK rise, lsb toward TDO
	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			state <= `SBST_TLR;
			ir_shift <= `SBST_IR_IDCODE;
			ir <= `SBST_IR_IDCODE;
			skip <= 1'b0;
			id_shift <= {`SBST_ID_LEN{1'b0}};
			bsr <= {`SBST_BSR_LEN{1'b0}};
			RING_OUT <= {`SBST_BSR_LEN{1'b0}};
			RING_OUT[`SBST_BSR_OE_BIT] <= 1'b1;
		end else if (rise) begin
			state <= next_state;
			case (state)
				`SBST_TLR: begin
					ir <= `SBST_IR_IDCODE;
					ir_shift <= `SBST_IR_IDCODE;
					RING_OUT[`SBST_BSR_OE_BIT] <= 1'b1;
				end
				`SBST_CAPIR: ir_shift <= {1'b0, `SBST_IR_CAPTURE};
				`SBST_SHIR: ir_shift <= {tdi, ir_shift[`SBST_IR_LEN-1:1]};
				`SBST_UPIR: ir <= ir_shift;
				`SBST_CAPDR: begin
					skip <= 1'b0;
					id_shift <= id_value;
					bsr <= RING_IN;
				end
				`SBST_SHDR: begin
					if (bsr_sel)
						bsr <= {tdi, bsr[`SBST_BSR_LEN-1:1]};
					else if (ir == `SBST_IR_IDCODE)
						id_shift <= {tdi, id_shift[`SBST_ID_LEN-1:1]};
					else
						skip <= tdi;
				end
				`SBST_UPDR: begin
					// preload latch, oe cell at bit 108
					if (bsr_sel)
						RING_OUT <= bsr;
				end
				default: begin
				end
			endcase
			// entering reset restores IDCODE and presets the oe cell
			if (next_state == `SBST_TLR) begin
				ir <= `SBST_IR_IDCODE;
				ir_shift <= `SBST_IR_IDCODE;
				RING_OUT[`SBST_BSR_OE_BIT] <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// output drive control
	// ----------------------------------------
	// float wins under code 010, oe cell under EXTEST
	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			Q_OE <= 1'b1;
			RING_DRIVE <= 1'b0;
		end else begin
			Q_OE <= (ir == `SBST_IR_FLOAT) ? 1'b0 :
				(ir == `SBST_IR_EXTEST) ? RING_OUT[`SBST_BSR_OE_BIT] : 1'b1;
			RING_DRIVE <= (ir == `SBST_IR_EXTEST);
		end
	end

	// ----------------------------------------
	// TDO launch on falling edge
	// ----------------------------------------
	reg tdo_bit;
	always @* begin
		tdo_bit = skip;
		if (state == `SBST_SHIR)
			tdo_bit = ir_shift[0];
		else if (bsr_sel)
			tdo_bit = bsr[0];
		else if (ir == `SBST_IR_IDCODE)
			tdo_bit = id_shift[0];
	end
	// launched a half TCK after shifting, so the host samples a stable bit
	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			TDO <= 1'b0;
			TDO_OE <= 1'b0;
		end else if (fall) begin
			TDO <= tdo_bit;
			TDO_OE <= (state == `SBST_SHIR) | (state == `SBST_SHDR);
		end
	end
endmodule // sbst_tap

// ---- src/sbst_tap_regs.vh ----
`ifndef SBST_TAP_REGS_VH
`define SBST_TAP_REGS_VH
// ----------------------------------------
// instruction codes
// ----------------------------------------
`define SBST_IR_EXTEST 3'h0
`define SBST_IR_IDCODE 3'h1
`define SBST_IR_FLOAT 3'h2
`define SBST_IR_SAMPLE 3'h4
`define SBST_IR_BYPASS 3'h7
// ----------------------------------------
// scan path lengths and field positions
// ----------------------------------------
`define SBST_IR_LEN 3
`define SBST_ID_LEN 32
`define SBST_BSR_LEN 109
`define SBST_BSR_OE_BIT 108
`define SBST_ID_REV_HI 31
`define SBST_ID_REV_LO 29
`define SBST_ID_PART_HI 28
`define SBST_ID_PART_LO 12
`define SBST_ID_VEND_HI 11
`define SBST_ID_VEND_LO 1
`define SBST_ID_PRESENT 1'h1
`define SBST_IR_CAPTURE 2'h1
// ----------------------------------------
// tap states
// ----------------------------------------
`define SBST_TLR 4'hF
`define SBST_RTI 4'hC
`define SBST_SELDR 4'h7
`define SBST_CAPDR 4'h6
`define SBST_SHDR 4'h2
`define SBST_EX1DR 4'h1
`define SBST_PDR 4'h3
`define SBST_EX2DR 4'h0
`define SBST_UPDR 4'h5
`define SBST_SELIR 4'h4
`define SBST_CAPIR 4'hE
`define SBST_SHIR 4'hA
`define SBST_EX1IR 4'h9
`define SBST_PIR 4'hB
`define SBST_EX2IR 4'h8
`define SBST_UPIR 4'hD
`endif

// ---- testbench/sbst_ctl.sv ----
module sbst_ctl (
	output logic tck = 0,
	output logic tms = 1,
	output logic tdi = 0,
	input wire logic tdo
);
	timeunit 1ns / 100ps;
	// one tck period; tck stands still between calls
	task step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#62.5 o = tdo;
		tck = 1;
		#62.5 tck = 0;
	endtask
	task tap_reset;
		logic o;
		repeat (5) step(1, 0, o);
		step(0, 0, o);
	endtask
endmodule // sbst_ctl

// ---- testbench/sbst_tap_checker.sv ----
module sbst_chk (
	input wire CLOCK,
	input wire RST_N,
	input wire TCK,
	input wire TDO,
	input wire [108:0] RING_OUT,
	input wire RING_DRIVE,
	input wire Q_OE
);
	default clocking dc @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	sequence s_ext;
		RING_DRIVE ##1 RING_DRIVE && $stable(RING_OUT[108]);
	endsequence
	AST_TDO_FALL: assert property ($changed(TDO) |-> !TCK)
		else $error("tdo early");
	AST_TDO_HOLD: assert property ($changed(TDO) |=> $stable(TDO) [*8])
		else $error("tdo not held");
	AST_RST: assert property (
		$rose(RST_N) |-> Q_OE && !RING_DRIVE && RING_OUT == {1'h1, 108'h0})
		else $error("bad reset");
	AST_Q_TCK: assert property ($changed(Q_OE) |-> TCK)
		else $error("q_oe early");
	AST_DRV_TCK: assert property ($changed(RING_DRIVE) |-> TCK)
		else $error("drive early");
	AST_RING_TCK: assert property ($changed(RING_OUT) |-> TCK)
		else $error("ring early");
	AST_RING_HOLD: assert property (
		$changed(RING_OUT) |=> $stable(RING_OUT) [*8])
		else $error("ring not held");
	AST_EXT_OE: assert property (s_ext |-> Q_OE == RING_OUT[108])
		else $error("oe cell ignored");
endmodule // sbst_chk
bind sbst_tap sbst_chk chk (.CLOCK(CLOCK), .RST_N(RST_N), .TCK(TCK),
	.TDO(TDO), .RING_OUT(RING_OUT), .RING_DRIVE(RING_DRIVE), .Q_OE(Q_OE));

// ---- testbench/tb_top.sv ----
`include "sbst_tap_regs.vh"
module tb_top;
	timeunit 1ns / 100ps;
	localparam [108:0] PIN = {1'h0, {27{4'hA}}}, PAT = {1'h0, {27{4'h5}}};
	logic clock = 0, rst_n = 0, o;
	logic [108:0] q;
	int fails = 0, n_compared = 0, cyc = 0;
	wire tck, tms, tdi, tdo, drive, q_oe, tdo_oe;
	wire [108:0] ring;
	always #4 clock = ~clock;
	sbst_tap uut (.CLOCK(clock), .RST_N(rst_n), .TCK(tck), .TMS(tms),
		.TDI(tdi), .RING_IN(PIN), .TDO(tdo), .TDO_OE(tdo_oe), .RING_OUT(ring),
		.RING_DRIVE(drive), .Q_OE(q_oe));
	sbst_ctl ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
	task chk(input logic [255:0] got, input logic [255:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t %h %h", $time, got, exp);
		end
	endtask
	task test_done;
		fails += (cyc > 20000);
		$display("compared %0d failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// idle, capture, shifts lsb first, update, idle
	task scan(input logic ir, input int n, input logic [108:0] d);
		repeat (1 + ir) ctl.step(1, 0, o);
		repeat (2) ctl.step(0, 0, o);
		for (int i = 0; i < n; i++)
			ctl.step(i == n - 1, d[i], q[i]);
		ctl.step(1, 0, o);
		ctl.step(0, 0, o);
	endtask
	// hang guard, well above the run
	always @(posedge clock)
		if (++cyc > 20000)
			test_done();
	initial begin
		repeat (5) @(negedge clock);
		rst_n = 1;
		chk({ring[108], q_oe, tdo_oe}, 3'h6);
		ctl.tap_reset();
		scan(0, 32, PAT);
		chk(q[31:0], {3'h0, 17'h00ABC, 11'h055, 1'h1});
		scan(1, 3, `SBST_IR_BYPASS);
		chk(q[2:0], 3'h1);
		scan(0, 4, 109'hB);
		chk(q[3:0], 4'h6);
		scan(1, 3, `SBST_IR_SAMPLE);
		scan(0, 109, PAT);
		chk({q, ring, q_oe}, {PIN, PAT, 1'h1});
		scan(1, 3, `SBST_IR_EXTEST);
		chk({drive, q_oe}, 2'h2);
		scan(0, 109, ~PAT);
		chk({q, q_oe}, {PIN, 1'h1});
		scan(1, 3, `SBST_IR_FLOAT);
		chk({drive, q_oe}, 2'h0);
		scan(0, 109, PAT);
		chk({q, ring[108], q_oe}, {PIN, 2'h0});
		ctl.tap_reset();
		chk({ring[108], q_oe, tdo_oe}, 3'h6);
		test_done();
	end
endmodule // tb_top
